/* core/conv_pkg.sv */
// Purpose: shared constants and types for the conversion sequencer
// Assumes: registers reached by an internal register port (address, strobes)
// Notes:   register field widths and counts named here

package conv_pkg;
  localparam logic [5:0] ADDR_CONVERTER_CONFIGURATION = 6'h01;
  localparam logic [5:0] ADDR_SHUNT_CALIBRATION       = 6'h02;
  localparam logic [5:0] ADDR_SHUNT_VOLTAGE_RESULT    = 6'h04;
  localparam logic [5:0] ADDR_BUS_VOLTAGE_RESULT      = 6'h05;

  localparam logic [15:0] CONFIG_RESET = 16'hfb68;
  localparam logic [15:0] CAL_RESET    = 16'h1000;
  localparam logic [15:0] CAL_MASK     = 16'h7fff;

  localparam int MODE_HI = 15;
  localparam int MODE_LO = 12;
  localparam int BCT_HI  = 11;
  localparam int BCT_LO  = 9;
  localparam int SCT_HI  = 8;
  localparam int SCT_LO  = 6;
  localparam int TCT_HI  = 5;
  localparam int TCT_LO  = 3;
  localparam int AVG_HI  = 2;
  localparam int AVG_LO  = 0;

  // mode field bits
  localparam int MODE_BUS_BIT    = 0;
  localparam int MODE_SHUNT_BIT  = 1;
  localparam int MODE_TEMP_BIT   = 2;
  localparam int MODE_CONT_BIT   = 3;

  localparam int CLK_MHZ = 200;
  // conversion times in microseconds, codes 0..7
  localparam int CT_US_0 = 50;
  localparam int CT_US_1 = 84;
  localparam int CT_US_2 = 150;
  localparam int CT_US_3 = 280;
  localparam int CT_US_4 = 540;
  localparam int CT_US_5 = 1052;
  localparam int CT_US_6 = 2074;
  localparam int CT_US_7 = 4120;

  localparam int AVG_N_0 = 1;
  localparam int AVG_N_1 = 4;
  localparam int AVG_N_2 = 16;
  localparam int AVG_N_3 = 64;
  localparam int AVG_N_4 = 128;
  localparam int AVG_N_5 = 256;
  localparam int AVG_N_6 = 512;
  localparam int AVG_N_7 = 1024;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_BUS   = 5'b00010,
    ST_SHUNT = 5'b00100,
    ST_TEMP  = 5'b01000,
    ST_DONE  = 5'b10000
  } seq_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic signed [15:0] shunt;
    logic        [15:0] bus;
    logic signed [15:0] temp;
  } samples_s;
endpackage

/* core/conv_seq.sv */
// Purpose: converter configuration, calibration and voltage result registers
// Assumes: samples arrive each cycle from the modulators; reg port is internal
// Notes:   conversion times are scaled by CT_SCALE_DIV for simulation

`timescale 1ns/1ps
`default_nettype none

// Operation
// - mode nibble at bits 15-12, resets Fh; codes 0 and 8 shut down
// - codes 1h-7h: single shot, bit0 bus, bit1 shunt, bit2 temperature
// - codes 9h-Fh convert continuously on the selected inputs
// - bus conversion time code at 11-9 selects 50 to 4120 us, reset 5
// - shunt conversion time code at 8-6, same encoding, reset 5
// - temperature conversion time code at 5-3, same encoding, reset 5
// - averaging code at 2-0 selects 1 to 1024 samples, reset 0
// - results update only after the whole averaging count completes
// - calibration holds 15-bit constant, reset 1000h, top bit reads zero
// - calibration constant sets current scaling and resolution
// - shunt result read-only 16-bit signed, reset zero, lsb per range
// - bus result read-only 16-bit, never negative, reset zero
// - range select input chooses shunt full-scale range
module conv_seq #(
  parameter int CT_SCALE_DIV = 1
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire conv_pkg::reg_req_s req,
  output logic             [15:0] rdata,
  output logic                    rvalid,
  input  wire conv_pkg::samples_s sample,
  input  wire logic               shunt_range_select,
  output logic                    shunt_fine_lsb,
  output logic             [14:0] current_scale_constant,
  output logic                    busy,
  output logic                    conv_ready
);

  function automatic int ct_cycles(input logic [2:0] code);
    int us;
    case (code)
      3'h0: us = conv_pkg::CT_US_0;
      3'h1: us = conv_pkg::CT_US_1;
      3'h2: us = conv_pkg::CT_US_2;
      3'h3: us = conv_pkg::CT_US_3;
      3'h4: us = conv_pkg::CT_US_4;
      3'h5: us = conv_pkg::CT_US_5;
      3'h6: us = conv_pkg::CT_US_6;
      default: us = conv_pkg::CT_US_7;
    endcase
    ct_cycles = (us * conv_pkg::CLK_MHZ) / CT_SCALE_DIV;
    if (ct_cycles < 1) begin
      ct_cycles = 1;
    end
  endfunction

  function automatic int avg_count(input logic [2:0] code);
    case (code)
      3'h0: avg_count = conv_pkg::AVG_N_0;
      3'h1: avg_count = conv_pkg::AVG_N_1;
      3'h2: avg_count = conv_pkg::AVG_N_2;
      3'h3: avg_count = conv_pkg::AVG_N_3;
      3'h4: avg_count = conv_pkg::AVG_N_4;
      3'h5: avg_count = conv_pkg::AVG_N_5;
      3'h6: avg_count = conv_pkg::AVG_N_6;
      default: avg_count = conv_pkg::AVG_N_7;
    endcase
  endfunction

  logic [15:0]          config_ff;
  logic [15:0]          cal_ff;
  logic signed [15:0]   shunt_res_ff;
  logic [15:0]          bus_res_ff;
  logic                 armed_ff;
  conv_pkg::seq_state_e state_ff;
  logic [19:0]          time_cnt_ff;
  logic [10:0]          avg_cnt_ff;
  logic signed [26:0]   shunt_acc_ff;
  logic [26:0]          bus_acc_ff;
  logic                 done_ff;

  logic [3:0] mode;
  logic       cfg_wr;
  logic       cal_wr;
  logic       mode_active;
  logic       slot_end;
  logic       last_sample;
  logic       en_bus;
  logic       en_shunt;
  logic       en_temp;
  logic [10:0] avg_n;

  assign mode        = config_ff[conv_pkg::MODE_HI:conv_pkg::MODE_LO];
  assign cfg_wr      = req.wr && (req.addr == conv_pkg::ADDR_CONVERTER_CONFIGURATION);
  assign cal_wr      = req.wr && (req.addr == conv_pkg::ADDR_SHUNT_CALIBRATION);
  assign en_bus      = mode[conv_pkg::MODE_BUS_BIT];
  assign en_shunt    = mode[conv_pkg::MODE_SHUNT_BIT];
  assign en_temp     = mode[conv_pkg::MODE_TEMP_BIT];
  // zero low bits means shutdown for both 0h and 8h
  assign mode_active = (mode[2:0] != 3'h0);
  assign avg_n       = 11'(avg_count(config_ff[conv_pkg::AVG_HI:conv_pkg::AVG_LO]));
  assign last_sample = (avg_cnt_ff == 11'(avg_n - 11'h1));

  always_comb begin
    case (state_ff)
      conv_pkg::ST_BUS:   slot_end = (time_cnt_ff ==
        20'(ct_cycles(config_ff[conv_pkg::BCT_HI:conv_pkg::BCT_LO]) - 1));
      conv_pkg::ST_SHUNT: slot_end = (time_cnt_ff ==
        20'(ct_cycles(config_ff[conv_pkg::SCT_HI:conv_pkg::SCT_LO]) - 1));
      conv_pkg::ST_TEMP:  slot_end = (time_cnt_ff ==
        20'(ct_cycles(config_ff[conv_pkg::TCT_HI:conv_pkg::TCT_LO]) - 1));
      default:            slot_end = 1'b0;
    endcase
  end

  // configuration register, all sixteen bits writable
  always_ff @(posedge mclk) begin
    if (rst) begin
      config_ff <= conv_pkg::CONFIG_RESET;
    end else if (cfg_wr) begin
      config_ff <= req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cal_ff <= conv_pkg::CAL_RESET;
    end else if (cal_wr) begin
      cal_ff <= req.wdata & conv_pkg::CAL_MASK;
    end
  end

  // single shot fires once per mode write, continuous rearms itself
  always_ff @(posedge mclk) begin
    if (rst) begin
      armed_ff <= 1'b1;
    end else if (cfg_wr) begin
      armed_ff <= 1'b1;
    end else if (state_ff == conv_pkg::ST_DONE && !mode[conv_pkg::MODE_CONT_BIT]) begin
      armed_ff <= 1'b0;
    end
  end

  // next enabled slot after the given one
  function automatic conv_pkg::seq_state_e next_slot(input conv_pkg::seq_state_e cur,
                                                     input logic b, input logic s, input logic t);
    next_slot = conv_pkg::ST_DONE;
    case (cur)
      conv_pkg::ST_IDLE: begin
        if (b) next_slot = conv_pkg::ST_BUS;
        else if (s) next_slot = conv_pkg::ST_SHUNT;
        else if (t) next_slot = conv_pkg::ST_TEMP;
      end
      conv_pkg::ST_BUS: begin
        if (s) next_slot = conv_pkg::ST_SHUNT;
        else if (t) next_slot = conv_pkg::ST_TEMP;
      end
      conv_pkg::ST_SHUNT: begin
        if (t) next_slot = conv_pkg::ST_TEMP;
      end
      default: next_slot = conv_pkg::ST_DONE;
    endcase
  endfunction

  always_ff @(posedge mclk) begin
    if (rst || cfg_wr) begin
      state_ff    <= conv_pkg::ST_IDLE;
      time_cnt_ff <= 20'h0;
    end else begin
      case (state_ff)
        conv_pkg::ST_IDLE: begin
          if (mode_active && armed_ff) begin
            state_ff <= next_slot(conv_pkg::ST_IDLE, en_bus, en_shunt, en_temp);
          end
          time_cnt_ff <= 20'h0;
        end
        conv_pkg::ST_BUS, conv_pkg::ST_SHUNT, conv_pkg::ST_TEMP: begin
          if (slot_end) begin
            state_ff    <= next_slot(state_ff, en_bus, en_shunt, en_temp);
            time_cnt_ff <= 20'h0;
          end else begin
            time_cnt_ff <= time_cnt_ff + 20'h1;
          end
        end
        conv_pkg::ST_DONE: begin
          // another pass until the averaging count is reached
          if (!last_sample) begin
            state_ff <= next_slot(conv_pkg::ST_IDLE, en_bus, en_shunt, en_temp);
          end else begin
            state_ff <= conv_pkg::ST_IDLE;
          end
        end
        default: state_ff <= conv_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || cfg_wr) begin
      avg_cnt_ff <= 11'h0;
    end else if (state_ff == conv_pkg::ST_DONE) begin
      avg_cnt_ff <= last_sample ? 11'h0 : avg_cnt_ff + 11'h1;
    end
  end

  // accumulators take a sample at the end of each bus and shunt slot; temperature slots are not accumulated
  always_ff @(posedge mclk) begin
    if (rst || cfg_wr) begin
      shunt_acc_ff <= 27'sh0;
      bus_acc_ff   <= 27'h0;
    end else if (state_ff == conv_pkg::ST_DONE && last_sample) begin
      shunt_acc_ff <= 27'sh0;
      bus_acc_ff   <= 27'h0;
    end else if (slot_end && state_ff == conv_pkg::ST_SHUNT) begin
      shunt_acc_ff <= shunt_acc_ff + 27'(sample.shunt);
    end else if (slot_end && state_ff == conv_pkg::ST_BUS) begin
      // negative raw bus samples clamp to zero
      bus_acc_ff <= bus_acc_ff + (sample.bus[15] ? 27'h0 : {11'h0, sample.bus});
    end
  end

  // division by power-of-two or 2^n-scaled counts; 1024 max fits 27 bits
  function automatic logic [26:0] avg_div(input logic [26:0] acc, input logic [2:0] code, input logic sgn);
    logic signed [26:0] s;
    s = $signed(acc);
    case (code)
      3'h0: avg_div = acc;
      3'h1: avg_div = sgn ? 27'(s >>> 2) : acc >> 2;
      3'h2: avg_div = sgn ? 27'(s >>> 4) : acc >> 4;
      3'h3: avg_div = sgn ? 27'(s >>> 6) : acc >> 6;
      3'h4: avg_div = sgn ? 27'(s >>> 7) : acc >> 7;
      3'h5: avg_div = sgn ? 27'(s >>> 8) : acc >> 8;
      3'h6: avg_div = sgn ? 27'(s >>> 9) : acc >> 9;
      default: avg_div = sgn ? 27'(s >>> 10) : acc >> 10;
    endcase
  endfunction

  logic [26:0] shunt_avg;
  logic [26:0] bus_avg;
  assign shunt_avg = avg_div(shunt_acc_ff, config_ff[conv_pkg::AVG_HI:conv_pkg::AVG_LO], 1'b1);
  assign bus_avg   = avg_div(bus_acc_ff, config_ff[conv_pkg::AVG_HI:conv_pkg::AVG_LO], 1'b0);

  // results load only once the averaging pass count is complete
  always_ff @(posedge mclk) begin
    if (rst) begin
      shunt_res_ff <= 16'sh0;
      bus_res_ff   <= 16'h0;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == conv_pkg::ST_DONE && last_sample && !cfg_wr) begin
        if (en_shunt) begin
          shunt_res_ff <= shunt_avg[15:0];
        end
        if (en_bus) begin
          bus_res_ff <= bus_avg[15:0];
        end
        done_ff <= 1'b1;
      end
    end
  end

  // read data; result registers have no write path at all
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata  <= 16'h0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        case (req.addr)
          conv_pkg::ADDR_CONVERTER_CONFIGURATION: rdata <= config_ff;
          conv_pkg::ADDR_SHUNT_CALIBRATION:       rdata <= cal_ff & conv_pkg::CAL_MASK;
          conv_pkg::ADDR_SHUNT_VOLTAGE_RESULT:    rdata <= shunt_res_ff;
          conv_pkg::ADDR_BUS_VOLTAGE_RESULT:      rdata <= bus_res_ff;
          default:                                rdata <= 16'h0;
        endcase
      end
    end
  end

  assign current_scale_constant = cal_ff[14:0];
  assign shunt_fine_lsb         = shunt_range_select;
  assign busy                   = (state_ff != conv_pkg::ST_IDLE);
  assign conv_ready             = done_ff;

  a_shutdown_idle: assert property (@(posedge mclk) disable iff (rst)
    (!mode_active && !$past(cfg_wr)) |-> state_ff == conv_pkg::ST_IDLE)
    else $error("converter left idle in shutdown");
  a_cal_top_zero: assert property (@(posedge mclk) disable iff (rst)
    cal_ff[15] == 1'b0)
    else $error("calibration reserved bit set");
  a_bus_not_neg: assert property (@(posedge mclk) disable iff (rst)
    bus_res_ff[15] == 1'b0)
    else $error("bus result negative");
  a_single_disarm: assert property (@(posedge mclk) disable iff (rst)
    (done_ff && !mode[conv_pkg::MODE_CONT_BIT] && !cfg_wr) |=> !armed_ff)
    else $error("single shot rearmed");
  a_result_hold: assert property (@(posedge mclk) disable iff (rst)
    !(state_ff == conv_pkg::ST_DONE && last_sample) |=> $stable(bus_res_ff))
    else $error("bus result moved mid average");
  a_result_ro: assert property (@(posedge mclk) disable iff (rst)
    (req.wr && req.addr == conv_pkg::ADDR_SHUNT_VOLTAGE_RESULT && !done_ff) |=> $stable(shunt_res_ff) || done_ff)
    else $error("result changed by write");
  a_mode_reset: assert property (@(posedge mclk)
    $past(rst) |-> config_ff == conv_pkg::CONFIG_RESET)
    else $error("configuration reset value wrong");
  a_range_follow: assert property (@(posedge mclk) disable iff (rst)
    shunt_fine_lsb == shunt_range_select)
    else $error("range select not followed");
  a_cont_restart: assert property (@(posedge mclk) disable iff (rst)
    (done_ff && mode[conv_pkg::MODE_CONT_BIT] && mode_active && !cfg_wr) |=> busy)
    else $error("continuous mode stopped");

endmodule

`default_nettype wire

/* verif/sample_source.sv */
// Purpose: stand-in for the modulators feeding the sequencer
// Assumes: analogue levels set by the bench, held between tests
// Notes:   one register stage, as a real modulator output would have

`timescale 1ns/1ps
`default_nettype none

module sample_source (
  input  wire logic               mclk,
  input  wire logic        [15:0] bus_level,
  input  wire logic        [15:0] shunt_level,
  input  wire logic        [15:0] temp_level,
  output var  conv_pkg::samples_s sample
);
  // samples lag the level by a cycle, never earlier
  always_ff @(posedge mclk) begin
    sample.bus   <= bus_level;
    sample.shunt <= shunt_level;
    sample.temp  <= temp_level;
  end
endmodule

`default_nettype wire

/* verif/adc_conversion_config_results_tb.sv */
// Purpose: self-checking bench for the conversion sequencer
// Assumes: CT_SCALE_DIV of 100, so one slot is 2 cycles per microsecond
// Notes:   slot lengths checked with a small margin for done and ready

`timescale 1ns/1ps
`default_nettype none

module adc_conversion_config_results_tb;
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_s;
  logic               mclk, rst, range_sel, rvalid, fine_lsb, busy, conv_ready;
  conv_pkg::reg_req_s req;
  conv_pkg::samples_s smp;
  logic        [15:0] rdata, lvl_bus, lvl_shunt, got;
  logic        [14:0] cal_const;
  logic        [3:0]  md;
  int                 num_errors, compares, cyc, n, k;
  int                 ct_us [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  int                 avg_n [5] = '{1, 4, 16, 64, 128};
  row_s               rows [9] = '{
    '{1'b0, 6'h01, 16'h0000, 16'hfb68}, '{1'b0, 6'h02, 16'h0000, 16'h1000},
    '{1'b0, 6'h04, 16'h0000, 16'h0000}, '{1'b0, 6'h05, 16'h0000, 16'h0000},
    '{1'b1, 6'h01, 16'h0b6d, 16'h0b6d}, '{1'b1, 6'h02, 16'hffff, 16'h7fff},
    '{1'b1, 6'h04, 16'h1234, 16'h0000}, '{1'b1, 6'h05, 16'habcd, 16'h0000},
    '{1'b1, 6'h03, 16'h5555, 16'h0000}};

  conv_seq #(.CT_SCALE_DIV(100)) i_dut (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .sample(smp), .shunt_range_select(range_sel), .shunt_fine_lsb(fine_lsb),
    .current_scale_constant(cal_const), .busy(busy), .conv_ready(conv_ready));

  sample_source i_src (.mclk(mclk), .bus_level(lvl_bus), .shunt_level(lvl_shunt),
    .temp_level(16'h0190), .sample(smp));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic in_range(int v, int lo, int hi);
    check({15'h0000, (v >= lo && v <= hi)}, 16'h0001);
  endtask

  // all drives start one step after a rising edge
  // strobe stays low for a full cycle so back-to-back calls never retoggle it
  task automatic wr(logic [5:0] a, logic [15:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req.wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(logic [5:0] a, output logic [15:0] d);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    #1;
    req.rd = 1'b0;
    d = rvalid ? rdata : 16'hdead;
    @(posedge mclk);
    #1;
  endtask

  // cycles until the next ready pulse, capped at lim
  task automatic wait_ready(int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
    end while (conv_ready !== 1'b1 && cnt < lim);
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    range_sel = 1'b0;
    lvl_bus = 16'h0123;
    lvl_shunt = 16'hfff0;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr)
        wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, got);
      check(got, rows[i].exp);
    end
    check({1'b0, cal_const}, 16'h7fff);
    $display("register rows done");
    range_sel = 1'b1;
    @(posedge mclk);
    #1;
    check({15'h0000, fine_lsb}, 16'h0001);
    range_sel = 1'b0;
    @(posedge mclk);
    #1;
    check({15'h0000, fine_lsb}, 16'h0000);
    $display("range select done");
    for (int m = 0; m < 16; m++) begin
      md = m[3:0];
      k = $countones(md[2:0]);
      wr(6'h01, {md, 12'h000});
      wait_ready(500, n);
      if (k == 0) begin
        in_range(n, 500, 500);
      end else begin
        in_range(n, 100 * k, 100 * k + 8);
        wait_ready(500, n);
        if (md[3])
          in_range(n, 100 * k - 2, 100 * k + 4);
        else
          in_range(n, 500, 500);
        if (!md[3])
          check({15'h0000, busy}, 16'h0000);
      end
    end
    rd(6'h05, got);
    check(got, 16'h0123);
    rd(6'h04, got);
    check(got, 16'hfff0);
    $display("mode codes done");
    for (int c = 0; c < 8; c++) begin
      wr(6'h01, {4'h1, c[2:0], 9'h000});
      wait_ready(9000, n);
      in_range(n, 2 * ct_us[c], 2 * ct_us[c] + 8);
    end
    wr(6'h01, 16'h2180);
    wait_ready(9000, n);
    in_range(n, 4148, 4156);
    wr(6'h01, 16'h4010);
    wait_ready(9000, n);
    in_range(n, 300, 308);
    $display("conversion times done");
    lvl_bus = 16'h0456;
    for (int a = 0; a < 5; a++) begin
      wr(6'h01, {4'h1, 9'h000, a[2:0]});
      wait_ready(14000, n);
      // each pass is one 100-cycle slot plus one done cycle
      in_range(n, 101 * avg_n[a], 101 * avg_n[a] + 8);
      rd(6'h05, got);
      check(got, 16'h0456);
    end
    wr(6'h01, 16'h3001);
    wait_ready(2000, n);
    in_range(n, 800, 808);
    lvl_bus = 16'h8000;
    wr(6'h01, 16'h1000);
    wait_ready(500, n);
    rd(6'h05, got);
    check(got, 16'h0000);
    $display("averaging done");
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    rd(6'h01, got);
    check(got, 16'hfb68);
    rd(6'h02, got);
    check(got, 16'h1000);
    $display("second reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
